// ==== inc/pbsp_pkg.sv ====
// package for the pipelined burst sram port: widths, burst constants, pipeline carrier
package pbsp_pkg;

    localparam int unsigned PBSP_ADDR_W      = 17;
    localparam int unsigned PBSP_LANES       = 4;
    localparam int unsigned PBSP_LANE_W      = 9;
    localparam int unsigned PBSP_DATA_W      = PBSP_LANES * PBSP_LANE_W;
    localparam int unsigned PBSP_BURST_LEN   = 4;
    localparam int unsigned PBSP_BURST_W     = 2;
    localparam int unsigned PBSP_DATA_DELAY  = 2;
    localparam int unsigned PBSP_BUF_DEPTH   = 2;
    localparam logic [1:0]  PBSP_CNT_RST     = 2'h0;

    // one pipeline slot: what the data cycle two edges later must do
    typedef struct packed {
        logic                       valid;
        logic                       is_read;
        logic [PBSP_ADDR_W-1:0]     addr;
        logic [PBSP_LANES-1:0]      lane_we;
    } pbsp_slot_s;

    localparam pbsp_slot_s PBSP_SLOT_IDLE = '{valid: 1'b0, is_read: 1'b0,
                                              addr: '0, lane_we: '0};

    typedef enum logic [1:0] {
        PBSP_IDLE   = 2'b00,
        PBSP_READ   = 2'b01,
        PBSP_WRITE  = 2'b11
    } pbsp_burst_e;

endpackage : pbsp_pkg

// ==== rtl/pbsp_port.sv ====
// pipelined burst sram port: host-facing synchronous port, burst counter and array
`timescale 1ns/1ps
module pbsp_port
    import pbsp_pkg::*;
#(
    parameter int unsigned ADDR_W = PBSP_ADDR_W,
    parameter int unsigned LANES  = PBSP_LANES,
    parameter int unsigned LANE_W = PBSP_LANE_W
)(
    // clock, reset and clock enable
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    input  wire logic                      clock_enable_n,
    // command pins
    input  wire logic [ADDR_W-1:0]         address_inputs,
    input  wire logic                      advance_or_load,
    input  wire logic                      read_not_write,
    input  wire logic                      chip_select_low_a,
    input  wire logic                      chip_select_low_b,
    input  wire logic                      chip_select_high,
    input  wire logic [LANES-1:0]          byte_write_enables_n,
    input  wire logic                      burst_order_select,
    input  wire logic                      output_enable_n,
    // two-way data pins
    input  wire logic [LANES*LANE_W-1:0]   data_bus_in,
    output logic      [LANES*LANE_W-1:0]   data_bus_out,
    output logic                           data_bus_oe
);

    localparam int unsigned DW    = LANES * LANE_W;
    localparam int unsigned DEPTH = 1 << ADDR_W;

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    logic                   run;
    logic                   selected;
    logic                   load_cmd;
    logic                   adv_cmd;
    logic [LANES-1:0]       lane_we;

    assign run      = ~clock_enable_n;
    assign selected = ~chip_select_low_a & ~chip_select_low_b & chip_select_high;
    assign load_cmd = ~advance_or_load & selected;
    assign adv_cmd  = advance_or_load;
    // byte enables only count for write cycles
    assign lane_we  = read_not_write ? '0 : ~byte_write_enables_n;

    ////////////////////////////////////////////////////////////////////////////
    // burst state and address register

    pbsp_burst_e            burst_q;
    logic [ADDR_W-1:0]      base_q;
    logic [1:0]             cnt_q;
    logic [1:0]             step_cnt;
    logic [1:0]             low_bits;

    assign step_cnt = cnt_q + 2'h1;
    // only the low two address bits move; the rest stay at the loaded base
    assign low_bits = burst_order_select ? (base_q[1:0] ^ step_cnt)
                                         : (base_q[1:0] + step_cnt);

    // load address register
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            base_q <= '0;
        end
        else if (run && load_cmd)
        begin
            base_q <= address_inputs;
        end
    end

    // burst counter: restarts on a load, steps only inside an open burst
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cnt_q <= PBSP_CNT_RST;
        end
        else if (run)
        begin
            if (load_cmd)
            begin
                cnt_q <= PBSP_CNT_RST;
            end
            else if (adv_cmd && burst_q != PBSP_IDLE)
            begin
                cnt_q <= step_cnt;
            end
        end
    end

    // burst type; a deselected load closes the burst
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            burst_q <= PBSP_IDLE;
        end
        else if (run && !advance_or_load)
        begin
            if (selected)
            begin
                burst_q <= read_not_write ? PBSP_READ : PBSP_WRITE;
            end
            else
            begin
                burst_q <= PBSP_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-slot command pipeline; slot 1 enters its data cycle on the next enabled edge

    pbsp_slot_s             cur_slot;
    pbsp_slot_s             slot_q [PBSP_DATA_DELAY];

    always_comb
    begin
        cur_slot = PBSP_SLOT_IDLE;
        if (load_cmd)
        begin
            cur_slot.valid   = 1'b1;
            cur_slot.is_read = read_not_write;
            cur_slot.addr    = address_inputs;
            cur_slot.lane_we = lane_we;
        end
        else if (adv_cmd && burst_q != PBSP_IDLE)
        begin
            cur_slot.valid   = 1'b1;
            cur_slot.is_read = (burst_q == PBSP_READ);
            cur_slot.addr    = {base_q[ADDR_W-1:2], low_bits};
            cur_slot.lane_we = (burst_q == PBSP_READ) ? '0 : lane_we;
        end
        // a deselect leaves an idle slot, older slots keep moving
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            slot_q[0] <= PBSP_SLOT_IDLE;
        end
        else if (run)
        begin
            slot_q[0] <= cur_slot;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            slot_q[1] <= PBSP_SLOT_IDLE;
        end
        else if (run)
        begin
            slot_q[1] <= slot_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data cycle tracking and registered data paths

    pbsp_slot_s             dcy_q;
    pbsp_slot_s             wr_slot_q;
    logic [DW-1:0]          wr_data_q;
    logic [DW-1:0]          rd_word;
    logic [DW-1:0]          rd_q;
    logic                   drive_q;

    // slot whose data cycle runs now, two enabled edges after its command
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            dcy_q <= PBSP_SLOT_IDLE;
        end
        else if (run)
        begin
            dcy_q <= slot_q[1];
        end
    end

    // write data is sampled on the edge that ends the data cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wr_data_q <= '0;
            wr_slot_q <= PBSP_SLOT_IDLE;
        end
        else if (run)
        begin
            wr_data_q <= data_bus_in;
            wr_slot_q <= dcy_q;
        end
    end

    // each lane owns its slice of the array; commit one edge after capture
    // keeps the byte strobes aligned with the data they qualify
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            logic [LANE_W-1:0]  lane_mem [DEPTH];
            logic [LANE_W-1:0]  lane_rd;
            logic               fwd_bus;
            logic               fwd_cap;

            // back-to-back turnaround: a read may follow a write to the same
            // word before the array holds it, the newest write wins
            assign fwd_bus = dcy_q.valid && !dcy_q.is_read && dcy_q.lane_we[g]
                             && (dcy_q.addr == slot_q[1].addr);
            assign fwd_cap = wr_slot_q.valid && !wr_slot_q.is_read
                             && wr_slot_q.lane_we[g]
                             && (wr_slot_q.addr == slot_q[1].addr);

            always_comb
            begin
                if (fwd_bus)
                begin
                    lane_rd = data_bus_in[g*LANE_W +: LANE_W];
                end
                else if (fwd_cap)
                begin
                    lane_rd = wr_data_q[g*LANE_W +: LANE_W];
                end
                else
                begin
                    lane_rd = lane_mem[slot_q[1].addr];
                end
            end

            assign rd_word[g*LANE_W +: LANE_W] = lane_rd;

            always_ff @(posedge mclk)
            begin
                if (run && wr_slot_q.valid && !wr_slot_q.is_read
                    && wr_slot_q.lane_we[g])
                begin
                    lane_mem[wr_slot_q.addr] <= wr_data_q[g*LANE_W +: LANE_W];
                end
            end
        end
    endgenerate

    // read data registered on the edge that opens its data cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rd_q    <= '0;
            drive_q <= 1'b0;
        end
        else if (run)
        begin
            drive_q <= slot_q[1].valid && slot_q[1].is_read;
            if (slot_q[1].valid && slot_q[1].is_read)
            begin
                rd_q <= rd_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: output enable is the only path that bypasses the clock

    assign data_bus_out = rd_q;
    assign data_bus_oe  = drive_q & ~output_enable_n;

endmodule : pbsp_port

// ==== testbench/pbsp_host.sv ====
// host controller model: command pins, write data in each write's data cycle
`timescale 1ns/1ps
module pbsp_host
    import pbsp_pkg::*;
(
    input  wire logic              mclk,
    // command and data pins
    output logic                   clock_enable_n,
    output logic                   advance_or_load,
    output logic                   read_not_write,
    output logic [2:0]             sel,
    output logic [16:0]            address_inputs,
    output logic [3:0]             byte_write_enables_n,
    output logic                   output_enable_n,
    output logic [35:0]            data_bus_in
);
    // kind 1 write, 2 read, 3 released; slot 3 is the data cycle now running
    logic [1:0]  kq [4] = '{default: 2'h0};
    logic [35:0] dq [4];
    logic        lc = 1'b1;
    initial {clock_enable_n, advance_or_load, read_not_write, sel, output_enable_n} = 7'h08;
    initial {address_inputs, byte_write_enables_n, data_bus_in} = 57'h0;
    task automatic cmd(input logic cn, ad, rw, input logic [2:0] cs, input logic [16:0] a,
                       input logic [3:0] bw, input logic [35:0] d, input logic [1:0] k);
        @(posedge mclk);
        #1;
        // a frozen edge moves nothing down the pipe
        if (!lc)
            for (int i = 3; i > 0; i--)
            begin
                kq[i] = kq[i-1];
                dq[i] = dq[i-1];
            end
        // outside write data the bus toggles so stale values never match
        data_bus_in = (kq[3] == 2'h1) ? dq[3] : ~data_bus_in;
        {clock_enable_n, advance_or_load, read_not_write, sel} = {cn, ad, rw, cs};
        address_inputs = a;
        byte_write_enables_n = bw;
        kq[0] = k;
        dq[0] = d;
        lc = cn;
    endtask : cmd
endmodule : pbsp_host

// ==== testbench/pbsp_port_assertions.sv ====
// pin-level checks on the pipelined burst sram port
`timescale 1ns/1ps
module pbsp_port_assertions
    import pbsp_pkg::*;
(
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   sys_rst,
    // command pins
    input wire logic                   clock_enable_n,
    input wire logic                   advance_or_load,
    input wire logic                   read_not_write,
    input wire logic                   chip_select_low_a,
    input wire logic                   chip_select_low_b,
    input wire logic                   chip_select_high,
    input wire logic                   output_enable_n,
    // data pins
    input wire logic [PBSP_DATA_W-1:0] data_bus_out,
    input wire logic                   data_bus_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire sel = !chip_select_low_a && !chip_select_low_b && chip_select_high;
    wire en  = !clock_enable_n;
    wire rld = en && !advance_or_load && sel && read_not_write;
    wire wld = en && !advance_or_load && sel && !read_not_write;
    wire dsl = en && !advance_or_load && !sel;
    property p_rd; rld ##1 en [*2] |=> data_bus_oe || output_enable_n; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_wr; wld ##1 en [*2] |=> !data_bus_oe; endproperty
    a_wr: assert property (p_wr) else $error("bus driven on write");
    property p_dsl; dsl ##1 en [*2] |=> !data_bus_oe; endproperty
    a_dsl: assert property (p_dsl) else $error("bus driven after deselect");
    property p_pend; rld ##1 dsl ##1 (en && !output_enable_n) [*2] |=> $fell(data_bus_oe);
    endproperty
    a_pend: assert property (p_pend) else $error("pending read lost");
    property p_brst; rld ##1 en && advance_or_load ##1 en [*2] |=> data_bus_oe || output_enable_n;
    endproperty
    a_brst: assert property (p_brst) else $error("burst read not driven");
    property p_oe; output_enable_n |-> !data_bus_oe; endproperty
    a_oe: assert property (p_oe) else $error("driven while disabled");
    property p_hold; !en |=> $stable(data_bus_out) && ($stable(data_bus_oe) || $changed(output_enable_n));
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while frozen");
    property p_reg; $changed(data_bus_out) |-> $past(en); endproperty
    a_reg: assert property (p_reg) else $error("data moved without edge");
endmodule : pbsp_port_assertions
bind pbsp_port pbsp_port_assertions i_chk (.*);

// ==== testbench/pbsp_port_bench.sv ====
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ps
module pbsp_port_bench
    import pbsp_pkg::*;
();
    logic mclk = 1'b0, sys_rst = 1'b1, burst_order_select = 1'b0;
    logic clock_enable_n, advance_or_load, read_not_write, output_enable_n, data_bus_oe;
    logic [2:0]  sel;
    logic [16:0] address_inputs;
    logic [3:0]  byte_write_enables_n;
    logic [35:0] data_bus_in, data_bus_out, mem [int];
    int miscompares = 0, n_tests = 0;
    always #2.5 mclk = ~mclk;
    pbsp_host i_host (.*);
    pbsp_port i_dut (.*, .chip_select_low_a(sel[2]), .chip_select_low_b(sel[1]),
                     .chip_select_high(sel[0]));
    task automatic cmp(input logic [35:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic step(input logic cn, ad, rw, input logic [2:0] cs, input logic [16:0] a,
                        input logic [3:0] bw, input logic [1:0] k, input logic [35:0] d);
        i_host.cmd(cn, ad, rw, cs, a, bw, d, k);
        if (i_host.kq[3] == 2'h2)
            cmp(data_bus_out, i_host.dq[3]);
        if (i_host.kq[3] != 2'h0)
            cmp(data_bus_oe, i_host.kq[3] == 2'h2 && !output_enable_n);
    endtask : step
    task automatic idle(input logic [2:0] cs = 3'h4);
        step(1'b0, 1'b0, 1'b0, cs, 17'h0, 4'hF, 2'h3, 36'h0);
    endtask : idle
    task automatic wr(input logic [16:0] a, input logic [3:0] bw, input logic [35:0] d,
                      input logic ad = 1'b0);
        for (int g = 0; g < 4; g++)
            if (!bw[g])
                mem[a][g*9 +: 9] = d[g*9 +: 9];
        step(1'b0, ad, 1'b0, 3'h1, ad ? ~a : a, bw, 2'h1, d);
    endtask : wr
    task automatic rd(input logic [16:0] a, input logic ad = 1'b0, input logic [3:0] bw = 4'hF);
        step(1'b0, ad, 1'b1, 3'h1, ad ? ~a : a, bw, 2'h2, mem[a]);
    endtask : rd
    function automatic logic [16:0] badr(input logic [16:0] b, input int k);
        badr = b;
        badr[1:0] = burst_order_select ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k);
    endfunction : badr
    task automatic t_burst(input logic ord);
        sys_rst = 1'b1;
        burst_order_select = ord;
        repeat (2) idle();
        sys_rst = 1'b0;
        for (int k = 0; k < 4; k++)
            wr(17'h40 + 17'(k), 4'h0, 36'h111111111 * 36'(k + ord));
        rd(17'h41);
        for (int k = 1; k < 6; k++)
            rd(badr(17'h41, k), 1'b1);
        wr(17'h42, 4'h0, 36'hA5A5A5A5A);
        for (int k = 1; k < 4; k++)
            wr(badr(17'h42, k), 4'(k), 36'h0F0F0F0F0 + 36'(k), 1'b1);
        for (int k = 0; k < 4; k++)
            rd(17'h40 + 17'(k));
        repeat (3) idle();
        $display("burst test done");
    endtask : t_burst
    task automatic t_rw();
        wr(17'h10, 4'h0, 36'h123456789);
        wr(17'h11, 4'h0, 36'hFEDCBA987);
        wr(17'h10, 4'hA, 36'hAAAAAAAAA);
        rd(17'h10);
        rd(17'h11, 1'b0, 4'h0);
        rd(17'h11);
        repeat (3) idle();
        $display("rw test done");
    endtask : t_rw
    task automatic t_desel();
        for (int i = 0; i < 3; i++)
        begin
            rd(17'h10);
            idle(i == 0 ? 3'h5 : i == 1 ? 3'h3 : 3'h0);
            step(1'b0, 1'b1, 1'b1, 3'h1, 17'h10, 4'hF, 2'h3, 36'h0);
            repeat (2) idle();
        end
        $display("deselect test done");
    endtask : t_desel
    task automatic t_cen();
        rd(17'h43);
        repeat (2) step(1'b1, 1'b0, 1'b0, 3'h1, 17'h43, 4'h0, 2'h1, 36'h0);
        rd(17'h42);
        i_host.output_enable_n = 1'b1;
        repeat (3) idle();
        i_host.output_enable_n = 1'b0;
        rd(17'h43);
        repeat (3) idle();
        $display("freeze test done");
    endtask : t_cen
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial
    begin
        t_burst(1'b0);
        t_rw();
        t_desel();
        t_cen();
        t_burst(1'b1);
        close_out();
    end
    // about 80 cycles of traffic; the limit leaves ample slack
    initial
    begin
        #(5 * 1000);
        miscompares++;
        close_out();
    end
endmodule : pbsp_port_bench
